// ---- rtl/uartpp_pkg.sv ----
package uartpp_pkg;

  // ---------------------------------------------------------------------
  // Register indices; byte address is index times four
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'h98;
  localparam logic [7:0] IDX_DATA    = 8'h99;
  localparam logic [7:0] IDX_RELOAD  = 8'hA0;
  localparam logic [7:0] IDX_LOW     = 8'hA1;
  localparam logic [7:0] IDX_TCTRL   = 8'hA2;
  localparam int         BYTE_SHIFT  = 2;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int BIT_MODE   = 7;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_FILTER = 5;
  localparam int BIT_REN    = 4;
  localparam int BIT_TB8    = 3;
  localparam int BIT_RB8    = 2;
  localparam int BIT_TI     = 1;
  localparam int BIT_RI     = 0;
  localparam int BIT_RUN    = 0;
  localparam int BIT_IEN    = 1;

  // ---------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h40;
  localparam logic [7:0] RST_BYTE    = 8'h00;

  // ---------------------------------------------------------------------
  // Counts
  // ---------------------------------------------------------------------
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] DATA_BITS_8  = 4'h8;
  localparam logic [3:0] DATA_BITS_9  = 4'h9;
  localparam logic [7:0] TIMER_TOP    = 8'hFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } uartpp_rx_state_t;

  typedef enum logic [5:0] {
    SEL_NONE    = 6'h01,
    SEL_CONTROL = 6'h02,
    SEL_DATA    = 6'h04,
    SEL_RELOAD  = 6'h08,
    SEL_LOW     = 6'h10,
    SEL_TCTRL   = 6'h20
  } uartpp_sel_t;

endpackage

// ---- rtl/uartpp_port.sv ----
module uartpp_port #(
  parameter int ADDR_W = 12
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  input  wire logic                      baud_tick,
  input  wire logic                      serial_receive_pin,
  output logic                           serial_transmit_pin,
  output logic                           irq,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import uartpp_pkg::*;

  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------
  function automatic uartpp_sel_t decode_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] word;
    word = a[ADDR_W-1:BYTE_SHIFT];
    if (word == (ADDR_W-2)'(IDX_CONTROL)) begin
      decode_sel = SEL_CONTROL;
    end else if (word == (ADDR_W-2)'(IDX_DATA)) begin
      decode_sel = SEL_DATA;
    end else if (word == (ADDR_W-2)'(IDX_RELOAD)) begin
      decode_sel = SEL_RELOAD;
    end else if (word == (ADDR_W-2)'(IDX_LOW)) begin
      decode_sel = SEL_LOW;
    end else if (word == (ADDR_W-2)'(IDX_TCTRL)) begin
      decode_sel = SEL_TCTRL;
    end else begin
      decode_sel = SEL_NONE;
    end
  endfunction

  // -----------------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------------
  logic             frame_format_select;
  logic             address_filter_enable;
  logic             receive_enable_bit;
  logic             transmit_ninth_bit;
  logic             received_ninth_bit;
  logic             transmit_done_flag;
  logic             receive_done_flag;
  logic [7:0]       serial_data_buffer;
  logic [7:0]       baud_timer_reload_byte;
  logic [7:0]       baud_timer_low_byte;
  logic             timer_run;
  logic             irq_enable;

  // AXI write side
  logic              aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic              w_held;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              do_write;
  uartpp_sel_t       wsel;
  logic              wr_control;
  logic              wr_data;
  logic              wr_low;

  // Baud and frame state
  logic             timer_tick;
  logic             tx_ovf;
  logic             tx_half;
  logic             tx_baud;
  logic [7:0]       rx_timer;
  logic             rx_ovf;
  logic             rx_half;
  logic             rx_sample;
  logic             rx_prev;
  logic             start_det;
  logic [10:0]      tx_shift;
  logic [3:0]       tx_left;
  logic             tx_set;
  uartpp_rx_state_t rx_state;
  logic [3:0]       rx_count;
  logic [8:0]       rx_shift;
  logic             rx_mode;
  logic             rx_accept;
  logic [7:0]       rx_byte;
  logic             rx_ninth;
  logic [7:0]       control_view;
  logic [31:0]      read_word;
  uartpp_sel_t      rsel;

  // -----------------------------------------------------------------------
  // AXI4-Lite write channel
  // -----------------------------------------------------------------------
  // Address and data are held separately so either may arrive first
  // Readies follow the clock enable so no beat is taken while state is frozen
  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wsel          = decode_sel(aw_addr);
  assign wr_control    = do_write && w_lane0 && (wsel == SEL_CONTROL);
  assign wr_data       = do_write && w_lane0 && (wsel == SEL_DATA);
  assign wr_low        = do_write && w_lane0 && (wsel == SEL_LOW);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_byte  <= RST_BYTE;
      w_lane0 <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // AXI4-Lite read channel
  // -----------------------------------------------------------------------
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign rsel          = decode_sel(s_axi_araddr);

  assign control_view = {frame_format_select, 1'b1, address_filter_enable,
                         receive_enable_bit, transmit_ninth_bit, received_ninth_bit,
                         transmit_done_flag, receive_done_flag};

  always_comb begin
    read_word = '0;
    unique case (rsel)
      SEL_CONTROL: read_word[7:0] = control_view;
      SEL_DATA:    read_word[7:0] = serial_data_buffer;
      SEL_RELOAD:  read_word[7:0] = baud_timer_reload_byte;
      SEL_LOW:     read_word[7:0] = baud_timer_low_byte;
      SEL_TCTRL:   read_word[1:0] = {irq_enable, timer_run};
      SEL_NONE:    read_word      = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word;
        s_axi_rresp  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Control register and flags
  // -----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_format_select    <= RST_CONTROL[BIT_MODE];
      address_filter_enable  <= RST_CONTROL[BIT_FILTER];
      receive_enable_bit     <= RST_CONTROL[BIT_REN];
      transmit_ninth_bit     <= RST_CONTROL[BIT_TB8];
      baud_timer_reload_byte <= RST_BYTE;
      timer_run              <= 1'b0;
      irq_enable             <= 1'b0;
    end else if (ce) begin
      if (wr_control) begin
        frame_format_select   <= w_byte[BIT_MODE];
        address_filter_enable <= w_byte[BIT_FILTER];
        receive_enable_bit    <= w_byte[BIT_REN];
        transmit_ninth_bit    <= w_byte[BIT_TB8];
      end
      if (do_write && w_lane0 && (wsel == SEL_RELOAD)) begin
        baud_timer_reload_byte <= w_byte;
      end
      if (do_write && w_lane0 && (wsel == SEL_TCTRL)) begin
        timer_run  <= w_byte[BIT_RUN];
        irq_enable <= w_byte[BIT_IEN];
      end
    end
  end

  // A hardware set in the same cycle as a software write wins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      transmit_done_flag <= RST_CONTROL[BIT_TI];
      receive_done_flag  <= RST_CONTROL[BIT_RI];
    end else if (ce) begin
      if (tx_set) begin
        transmit_done_flag <= 1'b1;
      end else if (wr_control) begin
        transmit_done_flag <= w_byte[BIT_TI];
      end
      if (rx_accept) begin
        receive_done_flag <= 1'b1;
      end else if (wr_control) begin
        receive_done_flag <= w_byte[BIT_RI];
      end
    end
  end

  assign irq = irq_enable && (transmit_done_flag || receive_done_flag);

  // -----------------------------------------------------------------------
  // Baud timers
  // -----------------------------------------------------------------------
  assign timer_tick = baud_tick && timer_run;
  assign tx_ovf     = timer_tick && (baud_timer_low_byte == TIMER_TOP);
  assign tx_baud    = tx_ovf && tx_half;
  assign rx_ovf     = timer_tick && (rx_timer == TIMER_TOP);
  assign rx_sample  = rx_ovf && rx_half;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_timer_low_byte <= RST_BYTE;
      tx_half             <= 1'b0;
    end else if (ce) begin
      if (wr_low) begin
        baud_timer_low_byte <= w_byte;
      end else if (tx_ovf) begin
        baud_timer_low_byte <= baud_timer_reload_byte;
      end else if (timer_tick) begin
        baud_timer_low_byte <= baud_timer_low_byte + 8'h01;
      end
      if (tx_ovf) begin
        tx_half <= !tx_half;
      end
    end
  end

  // Reloading at the start edge puts the first overflow half a bit in,
  // so every second overflow after it lands near mid-bit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_timer <= RST_BYTE;
      rx_half  <= 1'b0;
    end else if (ce) begin
      if (start_det) begin
        rx_timer <= baud_timer_reload_byte;
        rx_half  <= 1'b1;
      end else begin
        if (rx_ovf) begin
          rx_timer <= baud_timer_reload_byte;
          rx_half  <= !rx_half;
        end else if (timer_tick) begin
          rx_timer <= rx_timer + 8'h01;
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Transmitter
  // -----------------------------------------------------------------------
  // One spare slot after the stop bit keeps a back-to-back write from
  // cutting the stop bit short
  assign tx_set = tx_baud && (tx_left == 4'h2);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift            <= '1;
      tx_left             <= '0;
      serial_transmit_pin <= 1'b1;
    end else if (ce) begin
      if (wr_data) begin
        if (frame_format_select) begin
          tx_shift <= {1'b1, transmit_ninth_bit, w_byte, 1'b0};
          tx_left  <= FRAME_BITS_9 + 4'h1;
        end else begin
          tx_shift <= {2'b11, w_byte, 1'b0};
          tx_left  <= FRAME_BITS_8 + 4'h1;
        end
      end else if (tx_baud && (tx_left != 4'h0)) begin
        serial_transmit_pin <= tx_shift[0];
        tx_shift            <= {1'b1, tx_shift[10:1]};
        tx_left             <= tx_left - 4'h1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Receiver
  // -----------------------------------------------------------------------
  assign start_det = (rx_state == RX_IDLE) && receive_enable_bit && timer_run
                     && rx_prev && !serial_receive_pin;
  assign rx_byte   = rx_mode ? rx_shift[7:0] : rx_shift[8:1];
  assign rx_ninth  = rx_mode ? rx_shift[8] : serial_receive_pin;

  always_comb begin
    rx_accept = 1'b0;
    if ((rx_state == RX_STOP) && rx_sample && !receive_done_flag) begin
      if (rx_mode) begin
        rx_accept = !address_filter_enable || rx_shift[8];
      end else begin
        rx_accept = !address_filter_enable || serial_receive_pin;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_prev  <= 1'b1;
      rx_state <= RX_IDLE;
      rx_count <= '0;
      rx_shift <= '0;
      rx_mode  <= 1'b0;
    end else if (ce) begin
      rx_prev <= serial_receive_pin;
      if (!receive_enable_bit) begin
        rx_state <= RX_IDLE;
      end else begin
        unique case (rx_state)
          RX_IDLE: begin
            if (start_det) begin
              rx_state <= RX_START;
              rx_mode  <= frame_format_select;
            end
          end
          RX_START: begin
            if (rx_sample) begin
              rx_state <= serial_receive_pin ? RX_IDLE : RX_DATA;
              rx_count <= '0;
            end
          end
          RX_DATA: begin
            if (rx_sample) begin
              rx_shift <= {serial_receive_pin, rx_shift[8:1]};
              rx_count <= rx_count + 4'h1;
              if (rx_count == (rx_mode ? DATA_BITS_9 : DATA_BITS_8) - 4'h1) begin
                rx_state <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_sample) begin
              rx_state <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Buffer holds until a later character is accepted
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_data_buffer <= RST_BYTE;
      received_ninth_bit <= RST_CONTROL[BIT_RB8];
    end else if (ce) begin
      if (rx_accept) begin
        serial_data_buffer <= rx_byte;
        received_ninth_bit <= rx_ninth;
      end
    end
  end

endmodule

// ---- bench/uartpp_port_chk.sv ----
module uartpp_port_chk
  import uartpp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic              serial_transmit_pin,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Address decode seen from outside
  // ----------
  logic [ADDR_W-1:0] idx;
  logic              mapped;
  assign idx = s_axi_araddr >> BYTE_SHIFT;
  assign mapped = idx inside {IDX_CONTROL, IDX_DATA, IDX_RELOAD, IDX_LOW, IDX_TCTRL};

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence both_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  write_answer_a: assert property (both_taken_s |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_answer_a: assert property (read_taken_s |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  ctrl_read_a: assert property (read_taken_s and idx == IDX_CONTROL |=>
    s_axi_rdata[6] && s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == RESP_OKAY)
    else $error("control read malformed");
  unmapped_read_a: assert property (read_taken_s and !mapped |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  start_bit_a: assert property ($fell(serial_transmit_pin) |=> !serial_transmit_pin)
    else $error("start bit too short");
  tx_idle_a: assert property ($rose(rst_b) |-> serial_transmit_pin[*2])
    else $error("transmit line not idle after reset");
endmodule

bind uartpp_port uartpp_port_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

// ---- bench/uartpp_peer_model.sv ----
module uartpp_peer_model #(
  parameter int BIT_TICKS = 8
) (
  input wire logic  ref_clk,
  input wire logic  baud_tick,
  input wire logic  tx_line,
  input wire logic  nine_mode,
  output logic       rx_line,
  output logic       got,
  output logic [8:0] got_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] w;

  initial begin
    rx_line = 1'b1;
    got = 1'b0;
    got_word = 9'h000;
  end

  // Peer shares the timer clock, so bit times are counted in ticks
  task automatic wait_ticks(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge ref_clk);
      if (baud_tick) k++;
    end
  endtask

  // Address characters carry ninth bit one, data characters zero
  task automatic send(input logic [7:0] d, input logic nb, input logic st);
    logic [10:0] f;
    int          len;
    f = nine_mode ? {st, nb, d, 1'b0} : {1'b1, st, d, 1'b0};
    len = nine_mode ? 11 : 10;
    for (int i = 0; i < len; i++) begin
      rx_line <= f[i];
      wait_ticks(BIT_TICKS);
    end
    rx_line <= 1'b1;
    wait_ticks(BIT_TICKS);
  endtask

  // Nine samples: eight data plus stop (8-bit) or ninth (9-bit)
  always begin
    @(negedge tx_line);
    wait_ticks(BIT_TICKS / 2);
    for (int i = 0; i < 9; i++) begin
      wait_ticks(BIT_TICKS);
      w[i] = tx_line;
    end
    got_word <= w;
    got <= 1'b1;
    @(posedge ref_clk);
    got <= 1'b0;
  end
endmodule

// ---- bench/uartpp_port_tb.sv ----
module uartpp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uartpp_pkg::*;
  localparam logic [7:0]  RELOAD = 8'hFC;
  localparam int          BIT_TICKS = 2 * (256 - RELOAD);
  localparam logic [11:0] A_CTRL = 12'(IDX_CONTROL) << BYTE_SHIFT;
  localparam logic [11:0] A_DATA = 12'(IDX_DATA) << BYTE_SHIFT;
  logic        ref_clk, rst_b, ce, baud_tick, serial_receive_pin, serial_transmit_pin, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, nine, got;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [8:0]  got_word;
  logic [15:0] tick_pat;
  logic [33:0] exp_rd[$];
  logic [8:0]  exp_tx[$];
  logic [1:0]  exp_b[$];
  int          error_cnt, tests_run;
  logic [7:0]  c, b, last;
  logic        ri, rb8, acc;
  logic [7:0]  tx_c[3] = '{8'h00, 8'h80, 8'h88};
  logic [7:0]  rx_c[6] = '{8'h10, 8'h10, 8'h30, 8'hB0, 8'hB0, 8'h00};
  logic [5:0]  rx_nb = 6'h10;
  logic [5:0]  rx_st = 6'h3B;
  logic [5:0]  rx_keep = 6'h02;

  uartpp_port i_dut (.*);
  uartpp_peer_model #(.BIT_TICKS(BIT_TICKS)) i_peer (.ref_clk(ref_clk), .baud_tick(baud_tick),
    .tx_line(serial_transmit_pin), .nine_mode(nine), .rx_line(serial_receive_pin),
    .got(got), .got_word(got_word));

  always #20 ref_clk = ~ref_clk;
  // Random but dense tick pattern keeps frames short
  always @(posedge ref_clk) begin
    baud_tick <= tick_pat[0];
    tick_pat <= {tick_pat[0], tick_pat[15:1]};
  end

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------
  // Register bus master
  // ----------
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rsp = RESP_OKAY);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    exp_b.push_back(rsp);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (s_axi_awready && !aw_ok) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    exp_rd.push_back(exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready) check("read", {s_axi_rresp, s_axi_rdata}, exp_rd.pop_front());
    if (got) check("frame", {25'h0, got_word}, {25'h0, exp_tx.pop_front()});
    if (s_axi_bvalid && s_axi_bready) check("bresp", {32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    complete_run();
  end

  // ----------
  // Main sequence
  // ----------
  initial begin
    void'($urandom(32'h4605));
    tick_pat = 16'h5555 | 16'($urandom);
    {ref_clk, rst_b, ce, nine} = 4'h2;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'hF};
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(A_CTRL, {RESP_OKAY, 24'h0, RST_CONTROL});
    rd(A_DATA, {RESP_OKAY, 24'h0, RST_BYTE});
    rd(12'h004, {RESP_SLVERR, 32'h0});
    wr(12'h004, 8'hFF, RESP_SLVERR);
    wr(A_CTRL, 8'hBC);
    rd(A_CTRL, {RESP_OKAY, 24'h0, 8'hF8});
    // Lane 0 disabled: the write must leave the control register alone
    s_axi_wstrb <= 4'hE;
    wr(A_CTRL, 8'h00);
    s_axi_wstrb <= 4'hF;
    rd(A_CTRL, {RESP_OKAY, 24'h0, 8'hF8});
    wr(12'(IDX_RELOAD) << BYTE_SHIFT, RELOAD);
    wr(12'(IDX_LOW) << BYTE_SHIFT, RELOAD);
    wr(12'(IDX_TCTRL) << BYTE_SHIFT, 8'h03);
    for (int k = 0; k < 3; k++) begin
      c = tx_c[k];
      wr(A_CTRL, c);
      nine = c[7];
      b = 8'($urandom);
      exp_tx.push_back({c[7] ? c[3] : 1'b1, b});
      wr(A_DATA, b);
      for (int n = 0; n < 400 && exp_tx.size() != 0; n++) @(posedge ref_clk);
      // A ninth-bit frame is reported half a bit before its stop bit begins
      repeat (2 * BIT_TICKS) @(posedge ref_clk);
      check("frame pending", 34'(exp_tx.size()), 34'h0);
      rd(A_CTRL, {RESP_OKAY, 24'h0, c | 8'h42});
      check("irq set", {33'h0, irq}, 34'h1);
      wr(A_CTRL, c);
      check("irq clear", {33'h0, irq}, 34'h0);
    end
    rd(A_DATA, {RESP_OKAY, 24'h0, RST_BYTE});
    {ri, rb8, last} = {2'b00, RST_BYTE};
    for (int k = 0; k < 6; k++) begin
      c = rx_c[k];
      if (!rx_keep[k]) begin
        wr(A_CTRL, c);
        ri = 1'b0;
      end
      nine = c[7];
      b = 8'($urandom);
      acc = c[4] && !ri && (!c[5] || (c[7] ? rx_nb[k] : rx_st[k]));
      i_peer.send(b, rx_nb[k], rx_st[k]);
      if (acc) begin
        {last, rb8, ri} = {b, c[7] ? rx_nb[k] : rx_st[k], 1'b1};
      end
      rd(A_CTRL, {RESP_OKAY, 24'h0, (c & 8'hB8) | 8'h40 | {5'h0, rb8, 1'b0, ri}});
      rd(A_DATA, {RESP_OKAY, 24'h0, last});
      check("irq rx", {33'h0, irq}, {33'h0, ri});
    end
    complete_run();
  end
endmodule
